// ==== inc/acr_map.svh ====
// register offsets, field positions and reset values of the clock routing block
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH
`define ACR_ADDR_RATE       7'h75
`define ACR_ADDR_ROUTE_ONE  7'h76
`define ACR_ADDR_ROUTE_TWO  7'h77
`define ACR_ADDR_REF_SEL    7'h78
`define ACR_ADDR_GATE       7'h7a
`define ACR_MASK_RATE       8'hcc
`define ACR_MASK_ROUTE_ONE  8'hff
`define ACR_MASK_ROUTE_TWO  8'h1f
`define ACR_MASK_REF_SEL    8'hc0
`define ACR_MASK_GATE       8'h27
`define ACR_RST_BYTE        8'h00
`define ACR_DAC_SEL         7:5
`define ACR_ADC_SEL         4:2
`define ACR_INT2_SEL        1:0
`define ACR_INT1_SEL        4:3
`define ACR_PLL2NET_SEL     2:1
`define ACR_PLL1NET_HALVE   0
`define ACR_REF2_BIT        7
`define ACR_REF1_BIT        6
`define ACR_RXPD_BIT        5
`define ACR_GATE1_BIT       2
`define ACR_GATE2_BIT       1
`define ACR_GATE3_BIT       0
`define ACR_RATE2           7:6
`define ACR_RATE1           3:2
`define ACR_RATE_RSVD       2'b01
`define ACR_NUM_CH          8
`define ACR_NUM_SRC         7
`define ACR_CH_DAC          0
`define ACR_CH_ADC          1
`define ACR_CH_INT1         2
`define ACR_CH_INT2         3
`define ACR_CH_PLL1NET      4
`define ACR_CH_PLL2NET      5
`define ACR_CH_REF1         6
`define ACR_CH_REF2         7
`endif

// ==== inc/acr_pkg.sv ====
// types shared by the clock routing block
package acr_pkg;
  typedef logic [7:0] acr_byte_t;
  typedef logic [6:0] acr_addr_t;
  typedef enum logic [1:0] {
    ACR_ST_RUN  = 2'b01,
    ACR_ST_PARK = 2'b10
  } acr_mux_state_t;
  typedef enum logic [1:0] {
    ACR_RATE_48K  = 2'b00,
    ACR_RATE_32K  = 2'b10,
    ACR_RATE_44K1 = 2'b11
  } acr_rate_t;
endpackage

// ==== inc/acr_sel_if.sv ====
// select, sources and output of one glitch free clock multiplexer
`timescale 1ns/100ps
interface acr_sel_if;
  logic [2:0] sel;
  logic [7:0] src;
  logic       out;
  logic       busy;
  logic [2:0] active;
  modport mux  (input sel, input src, output out, output busy, output active);
  modport user (output sel, output src, input out, input busy, input active);
endinterface // acr_sel_if

// ==== logic/acr_glitch_mux.sv ====
// glitch free eight way clock multiplexer sampled on the system clock
`timescale 1ns/100ps
module acr_glitch_mux (
  input  wire logic clk_sys,
  input  wire logic reset,
  acr_sel_if.mux    lnk
);
  import acr_pkg::*;

  acr_mux_state_t st_q;
  acr_mux_state_t st_d;
  logic [2:0]     cur_q;
  logic           out_q;
  logic           cur_level;
  logic           want_move;

  assign cur_level = lnk.src[cur_q];
  assign want_move = (lnk.sel != cur_q) && !cur_level;

  always_comb begin
    case (st_q)
      ACR_ST_RUN:  st_d = want_move ? ACR_ST_PARK : ACR_ST_RUN;
      ACR_ST_PARK: st_d = (lnk.sel == cur_q && !cur_level) ? ACR_ST_RUN : ACR_ST_PARK;
      default:     st_d = ACR_ST_RUN;
    endcase
  end

  // old source parked low, new one taken on its low phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q  <= ACR_ST_RUN;
      cur_q <= 3'h0;
      out_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cur_q <= (st_d == ACR_ST_PARK) ? lnk.sel : cur_q;
      out_q <= (st_d == ACR_ST_RUN) && cur_level;
    end
  end

  assign lnk.out    = out_q;
  assign lnk.busy   = (st_q == ACR_ST_PARK);
  assign lnk.active = cur_q;

  park_low_a: assert property (@(posedge clk_sys) disable iff (reset)
    (st_q == ACR_ST_PARK) |-> !out_q) else $error("output not low while parked");
endmodule // acr_glitch_mux

// ==== logic/acr_clock_route.sv ====
// audio clock routing: control registers, source muxes, pll nets and clock gates
// Overview of operation
// - dac select: xtal, mclk, pll nets, receiver
// - adc select uses the dac encoding
// - second internal clock picks four sources
// - first internal clock select in bits 4:3
// - second pll net: rate two or three, halved
// - first pll net: rate one or halved
// - bit 7 picks second pll reference
// - bit 6 picks first pll reference
// - power down bit stops the receiver
// - first system clock out enabled when zero
// - second system clock out enabled when zero
// - third system clock out enabled when zero
// - first pll rate field, 01 reserved
// - second pll rate field, same encoding
`timescale 1ns/100ps
`include "acr_map.svh"
module acr_clock_route (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire acr_pkg::acr_addr_t reg_addr,
  input  wire acr_pkg::acr_byte_t reg_wdata,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  output acr_pkg::acr_byte_t     reg_rdata,
  input  wire logic              crystal_clock_input,
  input  wire logic              master_clock_input,
  input  wire logic              first_pll_rate_output,
  input  wire logic              second_pll_rate_output,
  input  wire logic              third_rate_output,
  input  wire logic              receiver_clock_512,
  input  wire logic              receiver_clock_256,
  output logic                   dac_clock,
  output logic                   adc_clock,
  output logic                   first_internal_clock,
  output logic                   second_internal_clock,
  output logic                   first_internal_pll_clock,
  output logic                   second_internal_pll_clock,
  output logic                   first_pll_reference,
  output logic                   second_pll_reference,
  output acr_pkg::acr_rate_t     first_pll_rate_field,
  output acr_pkg::acr_rate_t     second_pll_rate_field,
  output logic                   receiver_power_down,
  output logic                   system_clock_out_one,
  output logic                   system_clock_out_one_oe,
  output logic                   system_clock_out_two,
  output logic                   system_clock_out_two_oe,
  output logic                   system_clock_out_three,
  output logic                   system_clock_out_three_oe
);
  import acr_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [`ACR_NUM_SRC-1:0] raw_w;
  logic [`ACR_NUM_SRC-1:0] meta_q;
  logic [`ACR_NUM_SRC-1:0] sync_q;
  logic                    xtal_s;
  logic                    mclk_s;
  logic                    rate1_s;
  logic                    rate2_s;
  logic                    rate3_s;
  logic                    rx512_s;
  logic                    rx256_s;

  assign raw_w = {receiver_clock_256, receiver_clock_512, third_rate_output,
                  second_pll_rate_output, first_pll_rate_output,
                  master_clock_input, crystal_clock_input};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw_w;
      sync_q <= meta_q;
    end
  end

  assign {rx256_s, rx512_s, rate3_s, rate2_s, rate1_s, mclk_s, xtal_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // halved rate outputs

  logic [2:0] rate_now;
  logic [2:0] rate_old_q;
  logic [2:0] half_q;
  logic [2:0] rate_rise;

  assign rate_now  = {rate3_s, rate2_s, rate1_s};
  assign rate_rise = rate_now & ~rate_old_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rate_old_q <= 3'h0;
      half_q     <= 3'h0;
    end else begin
      rate_old_q <= rate_now;
      half_q     <= half_q ^ rate_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  acr_byte_t route_one_q;
  acr_byte_t route_two_q;
  acr_byte_t ref_sel_q;
  acr_byte_t gate_q;
  acr_byte_t rate_q;
  acr_byte_t rdata_q;
  acr_byte_t rd_mux;
  acr_byte_t rate_wr;
  logic      wr_one;
  logic      wr_two;
  logic      wr_ref;
  logic      wr_gate;
  logic      wr_rate;
  logic      rsv1;
  logic      rsv2;

  assign wr_one  = reg_wr_en && (reg_addr == `ACR_ADDR_ROUTE_ONE);
  assign wr_two  = reg_wr_en && (reg_addr == `ACR_ADDR_ROUTE_TWO);
  assign wr_ref  = reg_wr_en && (reg_addr == `ACR_ADDR_REF_SEL);
  assign wr_gate = reg_wr_en && (reg_addr == `ACR_ADDR_GATE);
  assign wr_rate = reg_wr_en && (reg_addr == `ACR_ADDR_RATE);
  assign rsv1    = (reg_wdata[`ACR_RATE1] == `ACR_RATE_RSVD);
  assign rsv2    = (reg_wdata[`ACR_RATE2] == `ACR_RATE_RSVD);
  // reserved rate code leaves the field as it was
  assign rate_wr = ({rsv2 ? rate_q[`ACR_RATE2] : reg_wdata[`ACR_RATE2], 2'b00,
                     rsv1 ? rate_q[`ACR_RATE1] : reg_wdata[`ACR_RATE1], 2'b00})
                   & `ACR_MASK_RATE;

  assign rd_mux = (reg_addr == `ACR_ADDR_ROUTE_ONE) ? route_one_q :
                  (reg_addr == `ACR_ADDR_ROUTE_TWO) ? route_two_q :
                  (reg_addr == `ACR_ADDR_REF_SEL)   ? ref_sel_q   :
                  (reg_addr == `ACR_ADDR_GATE)      ? gate_q      :
                  (reg_addr == `ACR_ADDR_RATE)      ? rate_q      : `ACR_RST_BYTE;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      route_one_q <= `ACR_RST_BYTE;
      route_two_q <= `ACR_RST_BYTE;
      ref_sel_q   <= `ACR_RST_BYTE;
      gate_q      <= `ACR_RST_BYTE;
      rate_q      <= `ACR_RST_BYTE;
      rdata_q     <= `ACR_RST_BYTE;
    end else begin
      if (wr_one)  route_one_q <= reg_wdata & `ACR_MASK_ROUTE_ONE;
      if (wr_two)  route_two_q <= reg_wdata & `ACR_MASK_ROUTE_TWO;
      if (wr_ref)  ref_sel_q   <= reg_wdata & `ACR_MASK_REF_SEL;
      if (wr_gate) gate_q      <= reg_wdata & `ACR_MASK_GATE;
      if (wr_rate) rate_q      <= rate_wr;
      rdata_q <= reg_rd_en ? rd_mux : `ACR_RST_BYTE;
    end
  end

  assign reg_rdata             = rdata_q;
  assign receiver_power_down   = gate_q[`ACR_RXPD_BIT];
  assign first_pll_rate_field  = acr_rate_t'(rate_q[`ACR_RATE1]);
  assign second_pll_rate_field = acr_rate_t'(rate_q[`ACR_RATE2]);

  ////////////////////////////////////////////////////////////////////////////
  // clock multiplexers

  logic [2:0] ch_sel [`ACR_NUM_CH];
  logic [7:0] ch_src [`ACR_NUM_CH];
  logic       ch_out [`ACR_NUM_CH];
  logic [7:0] four_way;

  assign four_way = {4'h0, ch_out[`ACR_CH_PLL2NET], ch_out[`ACR_CH_PLL1NET], mclk_s, xtal_s};

  assign ch_sel[`ACR_CH_DAC]     = route_one_q[`ACR_DAC_SEL];
  assign ch_src[`ACR_CH_DAC]     = {xtal_s, xtal_s, rx256_s, rx512_s, four_way[3:0]};
  assign ch_sel[`ACR_CH_ADC]     = route_one_q[`ACR_ADC_SEL];
  assign ch_src[`ACR_CH_ADC]     = {xtal_s, xtal_s, rx256_s, rx512_s, four_way[3:0]};
  assign ch_sel[`ACR_CH_INT1]    = {1'b0, route_two_q[`ACR_INT1_SEL]};
  assign ch_src[`ACR_CH_INT1]    = four_way;
  assign ch_sel[`ACR_CH_INT2]    = {1'b0, route_one_q[`ACR_INT2_SEL]};
  assign ch_src[`ACR_CH_INT2]    = four_way;
  assign ch_sel[`ACR_CH_PLL1NET] = {2'b00, route_two_q[`ACR_PLL1NET_HALVE]};
  assign ch_src[`ACR_CH_PLL1NET] = {6'h00, half_q[0], rate1_s};
  assign ch_sel[`ACR_CH_PLL2NET] = {1'b0, route_two_q[`ACR_PLL2NET_SEL]};
  assign ch_src[`ACR_CH_PLL2NET] = {4'h0, half_q[2], rate3_s, half_q[1], rate2_s};
  assign ch_sel[`ACR_CH_REF1]    = {2'b00, ref_sel_q[`ACR_REF1_BIT]};
  assign ch_src[`ACR_CH_REF1]    = {6'h00, mclk_s, xtal_s};
  assign ch_sel[`ACR_CH_REF2]    = {2'b00, ref_sel_q[`ACR_REF2_BIT]};
  assign ch_src[`ACR_CH_REF2]    = {6'h00, mclk_s, xtal_s};

  acr_sel_if lnk [`ACR_NUM_CH] ();

  genvar g;
  generate
    for (g = 0; g < `ACR_NUM_CH; g++) begin : g_mux
      assign lnk[g].sel = ch_sel[g];
      assign lnk[g].src = ch_src[g];
      assign ch_out[g]  = lnk[g].out;
      acr_glitch_mux u_mux (
        .clk_sys (clk_sys),
        .reset   (reset),
        .lnk     (lnk[g])
      );
    end
  endgenerate

  assign dac_clock                 = ch_out[`ACR_CH_DAC];
  assign adc_clock                 = ch_out[`ACR_CH_ADC];
  assign first_internal_clock      = ch_out[`ACR_CH_INT1];
  assign second_internal_clock     = ch_out[`ACR_CH_INT2];
  assign first_internal_pll_clock  = ch_out[`ACR_CH_PLL1NET];
  assign second_internal_pll_clock = ch_out[`ACR_CH_PLL2NET];
  assign first_pll_reference       = ch_out[`ACR_CH_REF1];
  assign second_pll_reference      = ch_out[`ACR_CH_REF2];

  ////////////////////////////////////////////////////////////////////////////
  // system clock output gates

  logic [2:0] sys_src;
  logic [2:0] sys_off;
  logic [2:0] sys_en_q;
  logic [2:0] sys_out_q;

  assign sys_src = {rate3_s, ch_out[`ACR_CH_PLL2NET], ch_out[`ACR_CH_PLL1NET]};
  assign sys_off = {gate_q[`ACR_GATE3_BIT], gate_q[`ACR_GATE2_BIT], gate_q[`ACR_GATE1_BIT]};

  generate
    for (g = 0; g < 3; g++) begin : g_gate
      // enable changes only while the source is low
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          sys_en_q[g]  <= 1'b0;
          sys_out_q[g] <= 1'b0;
        end else begin
          if (!sys_src[g]) sys_en_q[g] <= !sys_off[g];
          sys_out_q[g] <= sys_src[g] && sys_en_q[g];
        end
      end
      gate_off_a: assert property ($past(sys_off[g]) && !$past(sys_src[g])
        |-> !sys_en_q[g] ##1 !sys_out_q[g]) else $error("system clock not gated off");
    end
  endgenerate

  assign system_clock_out_one      = sys_out_q[0];
  assign system_clock_out_one_oe   = sys_en_q[0];
  assign system_clock_out_two      = sys_out_q[1];
  assign system_clock_out_two_oe   = sys_en_q[1];
  assign system_clock_out_three    = sys_out_q[2];
  assign system_clock_out_three_oe = sys_en_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  dac_xtal_a: assert property (!lnk[0].busy && lnk[0].active inside {3'h0, 3'h6, 3'h7}
    |=> dac_clock == $past(xtal_s)) else $error("dac clock not crystal");
  adc_rx_a: assert property (!lnk[1].busy && lnk[1].active == 3'h4
    |=> adc_clock == $past(rx512_s)) else $error("adc clock not receiver 512");
  int2_mclk_a: assert property (!lnk[3].busy && lnk[3].active == 3'h1
    |=> second_internal_clock == $past(mclk_s)) else $error("second clock not mclk");
  int1_pll_a: assert property (!lnk[2].busy && lnk[2].active == 3'h2
    |=> first_internal_clock == $past(ch_out[4])) else $error("first clock not pll net");
  pll2_half_a: assert property (!lnk[5].busy && lnk[5].active == 3'h3
    |=> second_internal_pll_clock == $past(half_q[2])) else $error("pll2 net not half rate");
  pll1_half_a: assert property (rate_rise[0] |=> half_q[0] != $past(half_q[0]))
    else $error("first rate half did not toggle");
  ref2_mclk_a: assert property (!lnk[7].busy && lnk[7].active == 3'h1
    |=> second_pll_reference == $past(mclk_s)) else $error("pll2 reference wrong");
  ref1_sel_a: assert property (wr_ref && !reg_wdata[`ACR_REF1_BIT]
    |=> lnk[6].sel == 3'h0) else $error("pll1 reference select wrong");
  rx_pd_a: assert property (wr_gate
    |=> receiver_power_down == $past(reg_wdata[`ACR_RXPD_BIT]))
    else $error("receiver power down wrong");
  rate_keep_a: assert property (wr_rate && rsv1
    |=> first_pll_rate_field == $past(first_pll_rate_field)) else $error("reserved rate taken");
  rate2_set_a: assert property (wr_rate && reg_wdata[`ACR_RATE2] == ACR_RATE_32K
    |=> second_pll_rate_field == ACR_RATE_32K) else $error("second rate not set");
  rsv_zero_a: assert property (reg_rd_en && reg_addr == `ACR_ADDR_ROUTE_TWO
    |=> reg_rdata[7:5] == 3'h0) else $error("reserved bits read nonzero");

  dac_to_pll_c: cover property (wr_one && reg_wdata[7:5] == 3'h3 ##[1:40] !lnk[0].busy);
  gate_off_c: cover property (wr_gate && reg_wdata[2] ##[1:40] !system_clock_out_one_oe);
  rate_rsv_c: cover property (wr_rate && rsv2);
endmodule // acr_clock_route

// ==== dv/tb_acr_clock_route.sv ====
// self-checking bench for the audio clock routing block
`timescale 1ns/100ps
`include "acr_map.svh"
module tb_acr_clock_route;
  import acr_pkg::*;
  localparam int HALF [7]    = '{3, 4, 5, 6, 7, 8, 9};
  localparam int DAC_EXP [8] = '{3, 4, 5, 6, 8, 9, 3, 3};
  localparam int NET2_EXP [4] = '{6, 12, 7, 14};
  localparam acr_addr_t ADDRS [6] = '{`ACR_ADDR_RATE, `ACR_ADDR_ROUTE_ONE, `ACR_ADDR_ROUTE_TWO,
                                      `ACR_ADDR_REF_SEL, `ACR_ADDR_GATE, 7'h79};
  localparam acr_byte_t MASKS [6] = '{`ACR_MASK_RATE, `ACR_MASK_ROUTE_ONE, `ACR_MASK_ROUTE_TWO,
                                      `ACR_MASK_REF_SEL, `ACR_MASK_GATE, 8'h00};
  logic       clk_sys;
  logic       reset;
  acr_addr_t  reg_addr;
  acr_byte_t  reg_wdata;
  logic       reg_wr_en;
  logic       reg_rd_en;
  acr_byte_t  reg_rdata;
  logic [6:0] src_q;
  int         tick;
  logic       dac_clock, adc_clock, int_one, int_two, net_one, net_two, ref_one, ref_two;
  acr_rate_t  rate_one, rate_two;
  logic       rx_pd;
  logic [2:0] sys_out;
  logic [2:0] sys_oe;
  wire  [8:0] obs = {sys_out[2], ref_two, ref_one, net_two, net_one, int_two, int_one,
                     adc_clock, dac_clock};
  int         miscompares;
  int         num_checks;

  acr_clock_route u_acr_clock_route (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .crystal_clock_input(src_q[0]), .master_clock_input(src_q[1]),
    .first_pll_rate_output(src_q[2]), .second_pll_rate_output(src_q[3]),
    .third_rate_output(src_q[4]), .receiver_clock_512(src_q[5]), .receiver_clock_256(src_q[6]),
    .dac_clock(dac_clock), .adc_clock(adc_clock), .first_internal_clock(int_one),
    .second_internal_clock(int_two), .first_internal_pll_clock(net_one),
    .second_internal_pll_clock(net_two), .first_pll_reference(ref_one),
    .second_pll_reference(ref_two), .first_pll_rate_field(rate_one),
    .second_pll_rate_field(rate_two), .receiver_power_down(rx_pd),
    .system_clock_out_one(sys_out[2]), .system_clock_out_one_oe(sys_oe[2]),
    .system_clock_out_two(sys_out[1]), .system_clock_out_two_oe(sys_oe[1]),
    .system_clock_out_three(sys_out[0]), .system_clock_out_three_oe(sys_oe[0]));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and source clocks with distinct half periods
  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    tick <= tick + 1;
    for (int i = 0; i < 7; i++) src_q[i] <= ((tick / HALF[i]) % 2) == 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // access, compare and report tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check_byte(input string what, input acr_byte_t exp, input acr_byte_t got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_len(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      miscompares++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input acr_addr_t a, input acr_byte_t d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input acr_addr_t a, input acr_byte_t exp);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    check_byte($sformatf("reg %h", a), exp, reg_rdata);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // high run length of one observed clock, in system cycles
  task automatic check_run(input int idx, input int exp);
    int n;
    int len;
    len = 0;
    for (n = 0; n < 200 && obs[idx] !== 1'b0; n++) @(negedge clk_sys);
    for (; n < 200 && obs[idx] !== 1'b1; n++) @(negedge clk_sys);
    for (; n < 200 && obs[idx] === 1'b1; n++) begin
      @(negedge clk_sys);
      len++;
    end
    if (n >= 200) begin
      miscompares++;
      $display("BAD clock %0d run expected %0d seen no edge", idx, exp);
      print_verdict();
    end else begin
      check_len($sformatf("clock %0d run", idx), exp, len);
    end
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    settle(8);
    reset <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    acr_byte_t v;
    logic [2:0] act;
    clk_sys = 1'b0;
    reset = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    miscompares = 0;
    num_checks = 0;
    settle(8);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(ADDRS[i], 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(ADDRS[i], 8'hff);
      rd_chk(ADDRS[i], MASKS[i]);
    end
    check_byte("rx power down", 8'h01, {7'h0, rx_pd});
    do_reset();
    for (int i = 0; i < 6; i++) rd_chk(ADDRS[i], 8'h00);
    check_byte("rx power down", 8'h00, {7'h0, rx_pd});
    $display("test registers done");
    wr(`ACR_ADDR_RATE, 8'h8c);
    check_byte("rate one", 8'h03, {6'h0, rate_one});
    check_byte("rate two", 8'h02, {6'h0, rate_two});
    wr(`ACR_ADDR_RATE, 8'h44);
    rd_chk(`ACR_ADDR_RATE, 8'h8c);
    wr(`ACR_ADDR_RATE, 8'h48);
    rd_chk(`ACR_ADDR_RATE, 8'h88);
    check_byte("rate one", 8'h02, {6'h0, rate_one});
    $display("test rates done");
    for (int c = 0; c < 8; c++) begin
      v = {c[2:0], c[2:0], c[1:0]};
      wr(`ACR_ADDR_ROUTE_ONE, v);
      rd_chk(`ACR_ADDR_ROUTE_ONE, v);
      settle(60);
      check_run(0, DAC_EXP[c]);
      check_run(1, DAC_EXP[c]);
      check_run(3, DAC_EXP[c % 4]);
    end
    $display("test converter selects done");
    for (int c = 0; c < 4; c++) begin
      v = {3'b000, c[1:0], c[1:0], c[0]};
      wr(`ACR_ADDR_ROUTE_TWO, v);
      rd_chk(`ACR_ADDR_ROUTE_TWO, v);
      settle(60);
      check_run(4, c[0] ? 10 : 5);
      check_run(5, NET2_EXP[c]);
      check_run(2, c == 0 ? 3 : c == 1 ? 4 : c == 2 ? (c[0] ? 10 : 5) : NET2_EXP[c]);
    end
    $display("test internal selects done");
    for (int c = 0; c < 4; c++) begin
      v = {c[1:0], 6'h00};
      wr(`ACR_ADDR_REF_SEL, v);
      rd_chk(`ACR_ADDR_REF_SEL, v);
      settle(60);
      check_run(6, c[0] ? 4 : 3);
      check_run(7, c[1] ? 4 : 3);
    end
    $display("test references done");
    wr(`ACR_ADDR_ROUTE_TWO, 8'h00);
    settle(60);
    check_byte("oe", 8'h07, {5'h0, sys_oe});
    check_run(8, 5);
    for (int g = 7; g >= 0; g--) begin
      wr(`ACR_ADDR_GATE, {5'h0, g[2:0]});
      settle(20);
      check_byte("oe", {5'h0, ~g[2:0]}, {5'h0, sys_oe});
      act = '0;
      repeat (40) begin
        @(negedge clk_sys);
        act = act | sys_out;
      end
      check_byte("sys active", {5'h0, ~g[2:0]}, {5'h0, act});
    end
    wr(`ACR_ADDR_GATE, 8'h20);
    check_byte("rx power down", 8'h01, {7'h0, rx_pd});
    $display("test gates done");
    print_verdict();
  end
endmodule // tb_acr_clock_route
